// ==== rtl/parallel_load_pll_divider_control.sv ====
// Contract
// - Host drives RF ratio word; unconnected inputs count as one.
// - RF buffer follows data while strobe high, holds while low.
// - Strobe high resets all counters and disables the charge pump.
// - Strobe low freezes buffers, loads counters and gain, runs everything.
// - Two gain bits choose pump current, buffered like the RF data.
// - Reference divider ratio from ten inputs, open inputs read one.
// - RF divider pulse per division, eight RF cycles long.
// - Reference pulse per division, lasting the reference high period.
// - Direction high sinks when RF leads; low inverts the sense.
// - Direction selects which output carries RF or reference pulses.
// - Divided outputs enabled only while output enable is high.
// - Lock output sink on only while loop judged locked.
module parallel_load_pll_divider_control #(
    parameter int LOCK_ERR_MAX = pll_ctrl_pkg::LOCK_ERR_MAX_DEF,
    parameter int LOCK_GOOD    = pll_ctrl_pkg::LOCK_GOOD_DEF
) (
    input  wire logic                              clk,
    input  wire logic                              reset_n,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [pll_ctrl_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [pll_ctrl_pkg::DATA_W-1:0]   pwdata,
    output logic      [pll_ctrl_pkg::DATA_W-1:0]   prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic                              rf_in,
    input  wire logic                              ref_in,
    output logic                                   first_div_out,
    output logic                                   second_div_out,
    output logic      [1:0]                        pump_current_out,
    output logic      [pll_ctrl_pkg::GAIN_W-1:0]   pump_gain_select,
    output logic                                   lock_sink_on
);
    import pll_ctrl_pkg::*;

    logic [15:0]           rf_word_q;
    logic [REF_W-1:0]      ref_ratio_q;
    logic                  strobe_q;
    logic                  dir_q;
    logic                  oe_q;
    logic [RATIO_W-1:0]    rf_buf_q;
    logic [GAIN_W-1:0]     gain_buf_q;
    logic [GAIN_W-1:0]     gain_sel_q;
    logic [DATA_W-1:0]     prdata_q;
    logic                  pready_q;
    logic                  pslverr_q;
    logic                  rf_prev_q;
    logic                  ref_prev_q;
    logic [REF_W-1:0]      ref_cnt_q;
    logic                  ref_pulse_q;
    logic                  rf_pulse_prev_q;
    logic                  ref_pulse_prev_q;
    logic                  rf_flag_q;
    logic                  ref_flag_q;
    logic [1:0]            pump_q;
    logic [LOCK_CNT_W-1:0] err_q;
    logic [LOCK_CNT_W-1:0] good_q;
    logic                  lock_q;
    logic                  first_q;
    logic                  second_q;
    logic                  divided_rf_pulse;
    logic                  divided_reference_pulse;
    logic                  rf_ev;
    logic                  ref_ev;
    logic                  rf_set;
    logic                  ref_set;
    logic                  apb_done;
    logic                  apb_wr;
    logic [DATA_W-1:0]     rd_mux;
    logic                  addr_ok;
    logic [REF_W-1:0]      ref_last;
    logic                  ref_rise;
    logic [REF_W-1:0]      ref_cnt_d;

    rf_div_if dvi ();

    rf_dual_modulus_divider u_rf_div (
        .clk     (clk),
        .reset_n (reset_n),
        .dv      (dvi.div)
    );

    // APB: one wait state, request completes with pready_q
    assign apb_done = psel && penable && pready_q;
    assign apb_wr = apb_done && pwrite && addr_ok;

    always_comb begin
        rd_mux  = '0;
        addr_ok = 1'b1;
        if (paddr == RF_WORD_OFF) begin
            rd_mux[15:0] = rf_word_q;
        end else if (paddr == REF_RATIO_OFF) begin
            rd_mux[REF_W-1:0] = ref_ratio_q;
        end else if (paddr == PIN_CONTROL_OFF) begin
            rd_mux[CTRL_STROBE_BIT] = strobe_q;
            rd_mux[CTRL_DIR_BIT]    = dir_q;
            rd_mux[CTRL_OE_BIT]     = oe_q;
        end else if (paddr == LOOP_STATUS_OFF) begin
            rd_mux[STAT_LOCK_BIT]   = lock_q;
            rd_mux[STAT_SINK_BIT]   = pump_q[PUMP_SINK_BIT];
            rd_mux[STAT_SOURCE_BIT] = pump_q[PUMP_SOURCE_BIT];
            rd_mux[STAT_RUN_BIT]    = !strobe_q;
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !addr_ok;
            prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_mux : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rf_word_q   <= RF_WORD_RST;
            ref_ratio_q <= REF_RATIO_RST;
            strobe_q    <= PIN_CONTROL_RST[CTRL_STROBE_BIT];
            dir_q       <= PIN_CONTROL_RST[CTRL_DIR_BIT];
            oe_q        <= PIN_CONTROL_RST[CTRL_OE_BIT];
        end else if (apb_wr) begin
            if (paddr == RF_WORD_OFF) begin
                rf_word_q <= pwdata[15:0];
            end else if (paddr == REF_RATIO_OFF) begin
                ref_ratio_q <= pwdata[REF_W-1:0];
            end else if (paddr == PIN_CONTROL_OFF) begin
                strobe_q <= pwdata[CTRL_STROBE_BIT];
                dir_q    <= pwdata[CTRL_DIR_BIT];
                oe_q     <= pwdata[CTRL_OE_BIT];
            end
        end
    end

    // gain bits share the buffer timing
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rf_buf_q   <= RF_WORD_RST[RATIO_W-1:0];
            gain_buf_q <= RF_WORD_RST[WORD_GAIN_LSB +: GAIN_W];
        end else if (strobe_q) begin
            rf_buf_q   <= rf_word_q[RATIO_W-1:0];
            gain_buf_q <= rf_word_q[WORD_GAIN_LSB +: GAIN_W];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gain_sel_q <= RF_WORD_RST[WORD_GAIN_LSB +: GAIN_W];
        end else if (!strobe_q) begin
            gain_sel_q <= gain_buf_q;
        end
    end

    assign dvi.hold = strobe_q;
    assign dvi.rf_edge = rf_in && !rf_prev_q;
    assign dvi.main_count = rf_buf_q[WORD_MAIN_LSB +: MAIN_W];
    assign dvi.swallow_count = rf_buf_q[SWAL_W-1:0];
    assign divided_rf_pulse = dvi.pulse;

    // Edge history of the sampled inputs and of the divided pulses
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rf_prev_q        <= 1'b0;
            ref_prev_q       <= 1'b0;
            rf_pulse_prev_q  <= 1'b0;
            ref_pulse_prev_q <= 1'b0;
        end else begin
            rf_prev_q        <= rf_in;
            ref_prev_q       <= ref_in;
            rf_pulse_prev_q  <= divided_rf_pulse;
            ref_pulse_prev_q <= divided_reference_pulse;
        end
    end

    // Ratio of zero behaves as one
    assign ref_last = (ref_ratio_q == '0) ? '0 : ref_ratio_q - 10'h001;
    assign ref_rise = ref_in && !ref_prev_q;

    // Pulse uses the count of the period just begun, else it splits in two
    assign ref_cnt_d = !ref_rise ? ref_cnt_q
                     : ((ref_cnt_q >= ref_last) ? '0 : ref_cnt_q + 10'h001);

    always_ff @(posedge clk) begin
        if (!reset_n || strobe_q) begin
            ref_cnt_q <= '0;
        end else begin
            ref_cnt_q <= ref_cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || strobe_q) begin
            ref_pulse_q <= 1'b0;
        end else begin
            ref_pulse_q <= ref_in && (ref_cnt_d == ref_last);
        end
    end

    assign divided_reference_pulse = ref_pulse_q;

    // Phase/frequency detector on leading edges
    assign rf_ev = divided_rf_pulse && !rf_pulse_prev_q;
    assign ref_ev = divided_reference_pulse && !ref_pulse_prev_q;
    assign rf_set = rf_flag_q || rf_ev;
    assign ref_set = ref_flag_q || ref_ev;

    // Both set clears both, so no dead band
    always_ff @(posedge clk) begin
        if (!reset_n || strobe_q) begin
            rf_flag_q  <= 1'b0;
            ref_flag_q <= 1'b0;
        end else if (rf_set && ref_set) begin
            rf_flag_q  <= 1'b0;
            ref_flag_q <= 1'b0;
        end else begin
            rf_flag_q  <= rf_set;
            ref_flag_q <= ref_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || strobe_q) begin
            pump_q <= 2'h0;
        end else if (dir_q) begin
            pump_q[PUMP_SINK_BIT]   <= rf_flag_q;
            pump_q[PUMP_SOURCE_BIT] <= ref_flag_q;
        end else begin
            pump_q[PUMP_SINK_BIT]   <= ref_flag_q;
            pump_q[PUMP_SOURCE_BIT] <= rf_flag_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || strobe_q) begin
            err_q  <= '0;
            good_q <= '0;
            lock_q <= 1'b0;
        end else if (ref_ev) begin
            err_q <= '0;
            if (err_q <= LOCK_CNT_W'(LOCK_ERR_MAX)) begin
                if (good_q >= LOCK_CNT_W'(LOCK_GOOD)) begin
                    lock_q <= 1'b1;
                end else begin
                    good_q <= good_q + 8'h01;
                end
            end else begin
                good_q <= '0;
                lock_q <= 1'b0;
            end
        end else if ((rf_flag_q || ref_flag_q) && err_q != '1) begin
            err_q <= err_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            first_q  <= 1'b0;
            second_q <= 1'b0;
        end else begin
            first_q  <= oe_q && (dir_q ? divided_rf_pulse : divided_reference_pulse);
            second_q <= oe_q && (dir_q ? divided_reference_pulse : divided_rf_pulse);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign first_div_out = first_q;
    assign second_div_out = second_q;
    assign pump_current_out = pump_q;
    assign pump_gain_select = gain_sel_q;
    assign lock_sink_on = lock_q;

    a_pump_off_strobe: assert property (@(posedge clk) disable iff (!reset_n)
        strobe_q |=> pump_current_out == 2'h0)
        else $error("pump active during strobe");
    a_ref_held: assert property (@(posedge clk) disable iff (!reset_n)
        strobe_q |=> ref_cnt_q == '0 && !divided_reference_pulse)
        else $error("reference counter not held");
    a_buf_frozen: assert property (@(posedge clk) disable iff (!reset_n)
        !strobe_q |=> $stable(rf_buf_q) && $stable(gain_buf_q))
        else $error("buffer changed with strobe low");
    a_buf_follow: assert property (@(posedge clk) disable iff (!reset_n)
        strobe_q |=> rf_buf_q == $past(rf_word_q[RATIO_W-1:0]))
        else $error("buffer not transparent");
    a_gain_load: assert property (@(posedge clk) disable iff (!reset_n)
        !strobe_q ##1 !strobe_q |=> pump_gain_select == $past(gain_buf_q, 2))
        else $error("gain not loaded from buffer");
    a_out_disabled: assert property (@(posedge clk) disable iff (!reset_n)
        !oe_q |=> !first_div_out && !second_div_out)
        else $error("output active while disabled");
    a_swap_low: assert property (@(posedge clk) disable iff (!reset_n)
        oe_q && !dir_q |=> first_div_out == $past(divided_reference_pulse)
                          && second_div_out == $past(divided_rf_pulse))
        else $error("outputs not swapped");
    a_dir_sense: assert property (@(posedge clk) disable iff (!reset_n)
        !strobe_q && dir_q && rf_flag_q && !ref_flag_q
        |=> pump_current_out[PUMP_SINK_BIT] && !pump_current_out[PUMP_SOURCE_BIT])
        else $error("pump sense wrong");
    a_ref_width: assert property (@(posedge clk) disable iff (!reset_n)
        divided_reference_pulse |-> $past(ref_in))
        else $error("reference pulse outside high period");
    a_lock_drop: assert property (@(posedge clk) disable iff (!reset_n)
        strobe_q |=> !lock_sink_on)
        else $error("lock held during strobe");
    a_lock_bad: assert property (@(posedge clk) disable iff (!reset_n)
        ref_ev && err_q > LOCK_CNT_W'(LOCK_ERR_MAX) |=> !lock_sink_on)
        else $error("lock kept after bad period");
    a_gain_hold: assert property (@(posedge clk) disable iff (!reset_n)
        strobe_q |=> $stable(pump_gain_select))
        else $error("gain changed during strobe");
    a_pump_single: assert property (@(posedge clk) disable iff (!reset_n)
        !(pump_current_out[PUMP_SINK_BIT] && pump_current_out[PUMP_SOURCE_BIT]))
        else $error("pump sinks and sources at once");
    a_swap_high: assert property (@(posedge clk) disable iff (!reset_n)
        oe_q && dir_q |=> first_div_out == $past(divided_rf_pulse)
                         && second_div_out == $past(divided_reference_pulse))
        else $error("outputs not routed");
    a_rf_held: assert property (@(posedge clk) disable iff (!reset_n)
        strobe_q |=> !divided_rf_pulse)
        else $error("RF divider running under strobe");
    c_strobe_fall: cover property (@(posedge clk) disable iff (!reset_n) $fell(strobe_q));
    c_lock_rise: cover property (@(posedge clk) disable iff (!reset_n) $rose(lock_q));
    c_swap_out: cover property (@(posedge clk) disable iff (!reset_n)
        !dir_q && second_div_out);
    c_both_flags: cover property (@(posedge clk) disable iff (!reset_n) rf_ev && ref_flag_q);
endmodule

// ==== rtl/pll_ctrl_pkg.sv ====
package pll_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RATIO_W = 14;
    localparam int MAIN_W = 11;
    localparam int SWAL_W = 3;
    localparam int GAIN_W = 2;
    localparam int REF_W = 10;
    localparam int PRESC_W = 4;

    // Register byte offsets
    localparam logic [7:0] RF_WORD_OFF = 8'h00;
    localparam logic [7:0] REF_RATIO_OFF = 8'h04;
    localparam logic [7:0] PIN_CONTROL_OFF = 8'h08;
    localparam logic [7:0] LOOP_STATUS_OFF = 8'h0C;

    // Field positions
    localparam int WORD_GAIN_LSB = 14;
    localparam int WORD_MAIN_LSB = 3;
    localparam int CTRL_STROBE_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_OE_BIT = 2;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_SINK_BIT = 1;
    localparam int STAT_SOURCE_BIT = 2;
    localparam int STAT_RUN_BIT = 3;
    localparam int PUMP_SINK_BIT = 0;
    localparam int PUMP_SOURCE_BIT = 1;

    // Reset values: open inputs read as ones
    localparam logic [15:0] RF_WORD_RST = 16'hFFFF;
    localparam logic [REF_W-1:0] REF_RATIO_RST = 10'h3FF;
    localparam logic [2:0] PIN_CONTROL_RST = 3'h7;

    // Prescaler moduli
    localparam logic [PRESC_W-1:0] PRESC_LOW_LAST = 4'h7;
    localparam logic [PRESC_W-1:0] PRESC_HIGH_LAST = 4'h8;

    // Lock detector counts
    localparam int LOCK_ERR_MAX_DEF = 4;
    localparam int LOCK_GOOD_DEF = 8;
    localparam int LOCK_CNT_W = 8;
endpackage

// ==== rtl/rf_div_if.sv ====
interface rf_div_if;
    import pll_ctrl_pkg::*;
    logic              hold;
    logic              rf_edge;
    logic [MAIN_W-1:0] main_count;
    logic [SWAL_W-1:0] swallow_count;
    logic              pulse;

    modport ctrl (output hold, output rf_edge, output main_count, output swallow_count,
                  input pulse);
    modport div (input hold, input rf_edge, input main_count, input swallow_count,
                 output pulse);
endinterface

// ==== rtl/rf_dual_modulus_divider.sv ====
module rf_dual_modulus_divider (
    input wire logic clk,
    input wire logic reset_n,
    rf_div_if.div    dv
);
    import pll_ctrl_pkg::*;

    logic [PRESC_W-1:0] presc_q;
    logic [MAIN_W-1:0]  main_q;
    logic [SWAL_W-1:0]  swal_q;
    logic               pulse_q;
    logic [PRESC_W-1:0] presc_last;

    // Divide by nine while swallowing, else by eight
    assign presc_last = (swal_q != '0) ? PRESC_HIGH_LAST : PRESC_LOW_LAST;

    always_ff @(posedge clk) begin
        if (!reset_n || dv.hold) begin
            presc_q <= '0;
            main_q  <= dv.main_count;
            swal_q  <= dv.swallow_count;
        end else if (dv.rf_edge) begin
            if (presc_q == presc_last) begin
                presc_q <= '0;
                if (main_q <= 11'h001) begin
                    main_q <= dv.main_count;
                    swal_q <= dv.swallow_count;
                end else begin
                    main_q <= main_q - 11'h001;
                    if (swal_q != '0) begin
                        swal_q <= swal_q - 3'h1;
                    end
                end
            end else begin
                presc_q <= presc_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || dv.hold) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= (main_q <= 11'h001);
        end
    end

    assign dv.pulse = pulse_q;

    a_presc_range: assert property (@(posedge clk) disable iff (!reset_n)
        presc_q <= PRESC_HIGH_LAST)
        else $error("prescaler count out of range");
    a_hold_reload: assert property (@(posedge clk) disable iff (!reset_n)
        dv.hold |=> (main_q == $past(dv.main_count)) && (presc_q == '0) && !pulse_q)
        else $error("counters not reloaded under strobe");
    c_rf_pulse: cover property (@(posedge clk) disable iff (!reset_n) $rose(pulse_q));
endmodule

// ==== verif/link_source.sv ====
module link_source (
    input  wire logic clk,
    input  wire logic run,
    output logic      rf_in,
    output logic      ref_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph_q = 2'h0;
    // Sources stand still between runs so both dividers start from one edge
    always @(posedge clk) begin
        if (!run) begin
            rf_in  <= 1'b0;
            ref_in <= 1'b0;
            ph_q   <= 2'h0;
        end else begin
            rf_in <= ~rf_in;
            ph_q  <= ph_q + 2'h1;
            if (ph_q == 2'h3) begin
                ref_in <= ~ref_in;
            end
        end
    end
endmodule

// ==== verif/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pll_ctrl_pkg::*;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              rf_in;
    logic              ref_in;
    logic              run = 1'b0;
    logic              first_div_out;
    logic              second_div_out;
    logic [1:0]        pump_current_out;
    logic [GAIN_W-1:0] pump_gain_select;
    logic              lock_sink_on;
    logic [31:0]       rdat;
    logic              rerr;
    int                err_total = 0;
    int                num_checks = 0;
    int                cycles = 0;
    int                hi, per, sk, so, bad;

    parallel_load_pll_divider_control #(.LOCK_ERR_MAX(6), .LOCK_GOOD(2)) u_dut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rf_in(rf_in), .ref_in(ref_in), .first_div_out(first_div_out),
        .second_div_out(second_div_out), .pump_current_out(pump_current_out),
        .pump_gain_select(pump_gain_select), .lock_sink_on(lock_sink_on));
    link_source u_src (.clk(clk), .run(run), .rf_in(rf_in), .ref_in(ref_in));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 8000 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic pick(input int w);
        return (w != 0) ? second_div_out : first_div_out;
    endfunction

    // Width and period of one pulse, in clk cycles
    task automatic meas(input int w, output int h, output int p);
        int n;
        n = 0;
        h = 0;
        p = 0;
        @(posedge clk);
        while (pick(w) !== 1'b0 && n < 3000) begin @(posedge clk); n++; end
        while (pick(w) !== 1'b1 && n < 3000) begin @(posedge clk); n++; end
        while (pick(w) === 1'b1 && n < 3000) begin h++; p++; @(posedge clk); n++; end
        while (pick(w) !== 1'b1 && n < 3000) begin p++; @(posedge clk); n++; end
    endtask

    // Counts pump sink and source cycles, and any divided or lock activity
    task automatic watch(input int n);
        sk = 0;
        so = 0;
        bad = 0;
        repeat (n) begin
            @(posedge clk);
            sk += pump_current_out[PUMP_SINK_BIT];
            so += pump_current_out[PUMP_SOURCE_BIT];
            bad += first_div_out + second_div_out + lock_sink_on;
        end
    endtask

    initial begin
        idle(10);
        reset_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, RF_WORD_OFF, 32'h0);
        chk("rf_word", rdat, 32'h0000FFFF);
        apb(1'b0, REF_RATIO_OFF, 32'h0);
        chk("ref_ratio", rdat, 32'h000003FF);
        apb(1'b0, PIN_CONTROL_OFF, 32'h0);
        chk("pin_control", rdat, 32'h00000007);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", rerr, 1'b1);
        chk("unmapped_data", rdat, 32'h0);
        chk("gain_rst", pump_gain_select, 2'h3);
        $display("test reset done");
        wr(RF_WORD_OFF, 32'h00008040);
        wr(RF_WORD_OFF, 32'h0000403B);
        wr(REF_RATIO_OFF, 32'h00000004);
        run <= 1'b1;
        watch(300);
        chk("held_pump", sk + so, 32'h0);
        chk("held_outs", bad, 32'h0);
        chk("held_gain", pump_gain_select, 2'h3);
        $display("test strobe_high done");
        wr(PIN_CONTROL_OFF, 32'h00000006);
        idle(4);
        chk("gain_load", pump_gain_select, 2'h1);
        meas(0, hi, per);
        chk("rf_hi", hi, 32'd16);
        chk("rf_per", per, 32'd118);
        meas(1, hi, per);
        chk("ref_hi", hi, 32'd4);
        chk("ref_per", per, 32'd32);
        watch(1000);
        chk("slow_rf_source", so > sk, 1'b1);
        wr(RF_WORD_OFF, 32'h00008040);
        meas(0, hi, per);
        chk("frozen_per", per, 32'd118);
        chk("frozen_gain", pump_gain_select, 2'h1);
        $display("test run done");
        wr(PIN_CONTROL_OFF, 32'h00000004);
        meas(0, hi, per);
        chk("swap_first", per, 32'd32);
        meas(1, hi, per);
        chk("swap_second", per, 32'd118);
        watch(1000);
        chk("slow_rf_sink", sk > so, 1'b1);
        wr(PIN_CONTROL_OFF, 32'h00000000);
        watch(300);
        chk("oe_off", bad, 32'h0);
        $display("test direction done");
        wr(PIN_CONTROL_OFF, 32'h00000003);
        run <= 1'b0;
        wr(RF_WORD_OFF, 32'h00000040);
        wr(REF_RATIO_OFF, 32'h00000010);
        wr(PIN_CONTROL_OFF, 32'h00000006);
        run <= 1'b1;
        idle(1600);
        chk("locked", lock_sink_on, 1'b1);
        apb(1'b0, LOOP_STATUS_OFF, 32'h0);
        chk("status_lock", rdat[STAT_LOCK_BIT], 1'b1);
        chk("status_run", rdat[STAT_RUN_BIT], 1'b1);
        chk("status_err", rerr, 1'b0);
        wr(PIN_CONTROL_OFF, 32'h00000007);
        idle(2);
        watch(200);
        chk("strobe_clears", sk + so + bad, 32'h0);
        wr(RF_WORD_OFF, 32'h0000003B);
        wr(PIN_CONTROL_OFF, 32'h00000006);
        sk = 0;
        repeat (3000) begin
            @(posedge clk);
            sk += lock_sink_on;
        end
        chk("unlocked", sk, 32'h0);
        chk("gain_zero", pump_gain_select, 2'h0);
        $display("test lock done");
        end_of_test();
    end
endmodule
